// *** ucg_pkg.sv ***
// Shared constants and types for the serial transceiver clock generator core.
// Assumes one 200 MHz system clock and an active-low asynchronous reset.
package ucg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and counts
   localparam int unsigned   DIV_W           = 12;
   localparam int unsigned   DATA_W          = 9;
   localparam int unsigned   FIFO_DEPTH      = 8;
   localparam int unsigned   FRAME_W         = 13;
   localparam logic [3:0]    OVS_NORMAL_LAST = 4'hF;  // 16 samples per bit
   localparam logic [3:0]    OVS_DOUBLE_LAST = 4'h7;  // 8 samples per bit
   localparam logic [3:0]    DATA_BITS_BASE  = 4'h5;
   localparam logic [3:0]    RX_SHIFT_W      = 4'hA;  // Data plus parity
   localparam logic [8:0]    DATA_MASK_FULL  = 9'h1FF;

   ////////////////////////////////////////////////////////////////////////////
   // States, Gray coded along the usual path
   typedef enum logic [1:0] {
      UCG_TX_IDLE  = 2'b00,
      UCG_TX_SHIFT = 2'b01
   } ucg_tx_state_t;

   typedef enum logic [1:0] {
      UCG_RX_IDLE  = 2'b00,
      UCG_RX_START = 2'b01,
      UCG_RX_DATA  = 2'b11,
      UCG_RX_STOP  = 2'b10
   } ucg_rx_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Whole state of the core
   typedef struct packed {
      logic [DIV_W-1:0]   baud_cnt;
      logic               xck;
      logic               xs1;
      logic               xs2;
      logic               xs3;
      logic               oe;
      ucg_tx_state_t      tx_st;
      logic [3:0]         tdiv;
      logic               tbuf_empty;
      logic [DATA_W-1:0]  tbuf;
      logic [FRAME_W-1:0] tframe;
      logic [3:0]         tleft;
      logic               txd;
      logic               txc;
      ucg_rx_state_t      rx_st;
      logic [3:0]         rcnt;
      logic [2:0]         vote;
      logic [3:0]         rbits;
      logic [9:0]         rsh;
      logic               hv;
      logic [DATA_W-1:0]  hdata;
      logic               hfe;
      logic               hpe;
      logic               tv;
      logic [DATA_W-1:0]  tdata;
      logic               tfe;
      logic               tpe;
      logic               ovr;
   } ucg_core_state_t;

   // Value after reset: line idle high, transmit buffer empty
   localparam ucg_core_state_t CORE_RST = '{tx_st: UCG_TX_IDLE, rx_st: UCG_RX_IDLE,
                                            tbuf_empty: 1'b1, txd: 1'b1, default: '0};

endpackage : ucg_pkg

// *** ucg_core.sv ***
// Clock generation, transmitter and receiver of the serial transceiver core.
// Assumes synchronous pin inputs and a far end that honours the link clock limit.
// How it works
// RULE_01 - Four clock modes; mode select picks asynchronous or synchronous.
// RULE_02 - In synchronous mode clock direction picks master (out) or slave (in).
// RULE_03 - Transfer clock pin driven only in synchronous master mode.
// RULE_04 - Divisor counter reloads at zero and on every low-byte write.
// RULE_05 - One baud tick per counter zero: system clock over divisor plus one.
// RULE_06 - Bit rate uses 16, 8 or 2 ticks per bit by mode.
// RULE_07 - Receiver recovery runs off the tick with 2, 8 or 16 states.
// RULE_08 - Divisor is twelve bits, high and low parts concatenated.
// RULE_09 - Double speed ignored in synchronous mode; software keeps it clear.
// RULE_10 - Double speed halves receiver samples per bit to eight.
// RULE_11 - Slave clock synchronised then edge detected, two cycles latency.
// RULE_12 - Remote master keeps the link clock below a quarter system clock.
// RULE_13 - Receive sampling on the edge opposite the transmit change edge.
// RULE_14 - Polarity zero: change on rising, sample on falling; one swaps.
// RULE_15 - Whole unit held disabled while the power-off bit is one; the transmit FIFO still accepts writes.
// RULE_16 - Single write buffer lets frames follow back to back.
// RULE_17 - Two-entry receive buffer; frame, overrun and parity errors flagged.
// RULE_18 - Frames of 5 to 9 data bits, 1 or 2 stops, hardware parity.
// RULE_19 - Three requests: transmit complete, buffer empty, receive complete.
// RULE_20 - Majority vote filter and false start rejection on receive.
// RULE_21 - Low start bit, high stop bits, line idles high.
// RULE_22 - Slave edges give one-cycle change and sample enables.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Transmit FIFO; depth is expected to be a power of two
module ucg_fifo #(
   parameter int unsigned W = 9,
   parameter int unsigned D = 8
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   // Fill side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // Drain side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int unsigned AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
      logic                rdy;
      logic                nonempty;
   } ucg_fifo_state_t;

   localparam ucg_fifo_state_t FIFO_RST = '{rdy: 1'b1, default: '0};

   ucg_fifo_state_t q;
   ucg_fifo_state_t d;
   logic            push;
   logic            pop;

   // Pointer and occupancy update
   always_comb begin
      d    = q;
      push = in_valid_i && q.rdy;
      pop  = out_ready_i && q.nonempty;
      if (push) begin
         d.mem[q.wp] = in_data_i;
         d.wp        = q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = q.rp + 1'b1;
      end
      if (push && !pop) begin
         d.cnt = q.cnt + 1'b1;
      end else if (pop && !push) begin
         d.cnt = q.cnt - 1'b1;
      end
      d.rdy      = d.cnt != (AW+1)'(D);
      d.nonempty = d.cnt != '0;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q <= FIFO_RST;
      end else begin
         q <= d;
      end
   end

   assign in_ready_o  = q.rdy;
   assign out_valid_o = q.nonempty;
   assign out_data_o  = q.mem[q.rp];
endmodule : ucg_fifo

////////////////////////////////////////////////////////////////////////////////
// Transceiver core
module ucg_core
   import ucg_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   // Configuration
   input  wire logic              serial_power_off_bit_i,
   input  wire logic              sync_mode_select_i,
   input  wire logic              double_speed_bit_i,
   input  wire logic              transfer_clock_direction_i,
   input  wire logic              sync_clock_polarity_i,
   input  wire logic [3:0]        baud_divisor_high_i,
   input  wire logic [7:0]        baud_divisor_low_i,
   input  wire logic              baud_divisor_low_wr_i,
   input  wire logic [2:0]        data_bits_i,
   input  wire logic [1:0]        parity_mode_i,
   input  wire logic              two_stop_i,
   input  wire logic              tx_enable_i,
   input  wire logic              rx_enable_i,
   // Transmit data
   input  wire logic [DATA_W-1:0] tx_data_i,
   input  wire logic              tx_valid_i,
   output logic                   tx_ready_o,
   // Receive data
   output logic [DATA_W-1:0]      rx_data_o,
   output logic                   rx_valid_o,
   input  wire logic              rx_ready_i,
   output logic                   rx_frame_err_o,
   output logic                   rx_parity_err_o,
   output logic                   rx_overrun_o,
   // Requests
   input  wire logic              tx_complete_clr_i,
   output logic                   tx_complete_o,
   output logic                   tx_buf_empty_o,
   output logic                   rx_complete_o,
   // Pins
   output logic                   serial_tx_pin_o,
   input  wire logic              serial_rx_pin_i,
   input  wire logic              transfer_clock_pin_i,
   output logic                   transfer_clock_pin_o,
   output logic                   transfer_clock_pin_oe_o
);

   // Last sample index of a bit period
   function automatic logic [3:0] ovs_last(input logic dbl);
      return dbl ? OVS_DOUBLE_LAST : OVS_NORMAL_LAST;
   endfunction : ovs_last

   // Frame image, start bit in bit 0, unused tail stays high
   function automatic logic [FRAME_W-1:0] ucg_frame(input logic [DATA_W-1:0] data,
                                                   input logic [3:0] nb, input logic [1:0] pm);
      logic [FRAME_W-1:0] f;
      logic               p;
      f    = '1;
      f[0] = 1'b0;
      p    = pm[0];
      for (int i = 0; i < DATA_W; i++) begin
         if (i < int'(nb)) begin
            f[i+1] = data[i];
            p      = p ^ data[i];
         end
      end
      if (pm[1]) begin
         f[nb+4'h1] = p;
      end
      return f;
   endfunction : ucg_frame

   ucg_core_state_t   q;
   ucg_core_state_t   d;
   logic              on;
   logic              sync;
   logic              master;
   logic              slave;
   logic              dbl;
   logic [3:0]        last;
   logic [DIV_W-1:0]  div;
   logic              tick;
   logic              rise;
   logic              fall;
   logic              change_en;
   logic              sample_en;
   logic              tx_bit_en;
   logic              rx_samp;
   logic              rbit;
   logic [3:0]        nbits;
   logic              par;
   logic [3:0]        rtotal;
   logic [3:0]        flen;
   logic [9:0]        rword;
   logic [DATA_W-1:0] rdata;
   logic              rpe;
   logic              rpush;
   logic              rfe;
   logic              f_valid;
   logic [DATA_W-1:0] f_data;

   ////////////////////////////////////////////////////////////////////////////
   // Transmit FIFO; full FIFO stalls the source through tx_ready_o
   ucg_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_tx_fifo (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .in_data_i   (tx_data_i),
      .out_valid_o (f_valid),
      .out_ready_i (q.tbuf_empty && on),  // RULE_15
      .out_data_o  (f_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode and clock enables
   always_comb begin
      on     = !serial_power_off_bit_i;                         // RULE_15
      sync   = sync_mode_select_i;                              // RULE_01
      master = sync && transfer_clock_direction_i;              // RULE_02
      slave  = sync && !transfer_clock_direction_i;             // RULE_02
      dbl    = double_speed_bit_i && !sync;                     // RULE_09
      last   = ovs_last(dbl);                                   // RULE_10
      div    = {baud_divisor_high_i, baud_divisor_low_i};       // RULE_08
      tick   = q.baud_cnt == '0;                                // RULE_05
      // Master edges come from the divider; slave edges from the synchroniser
      if (master) begin
         rise = tick && !q.xck;
         fall = tick && q.xck;
      end else begin
         rise = slave && q.xs2 && !q.xs3;                       // RULE_22
         fall = slave && !q.xs2 && q.xs3;                       // RULE_22
      end
      change_en = sync_clock_polarity_i ? fall : rise;          // RULE_14
      sample_en = sync_clock_polarity_i ? rise : fall;          // RULE_13
      tx_bit_en = sync ? change_en : (tick && q.tdiv == last);  // RULE_06
      rx_samp   = sync ? sample_en : (tick && q.rcnt == (last >> 1) + 4'h2); // RULE_07
      // Majority of three centre samples filters short glitches
      rbit = sync ? serial_rx_pin_i :
             ((q.vote[1] & q.vote[0]) | (q.vote[1] & serial_rx_pin_i) |
              (q.vote[0] & serial_rx_pin_i));                   // RULE_20
      nbits  = DATA_BITS_BASE + {1'b0, data_bits_i};            // RULE_18
      par    = parity_mode_i[1];
      rtotal = nbits + {3'b000, par};
      flen   = 4'h1 + nbits + {3'b000, par} + (two_stop_i ? 4'h2 : 4'h1);
      rword  = q.rsh >> (RX_SHIFT_W - rtotal);
      rdata  = rword[DATA_W-1:0] & (DATA_MASK_FULL >> (4'h9 - nbits));
      rpe    = par && ((^rdata) ^ rword[nbits] ^ parity_mode_i[0]); // RULE_17
      rpush  = on && rx_enable_i && q.rx_st == UCG_RX_STOP && rx_samp;
      rfe    = !rbit;                                           // RULE_21
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      d = q;
      // Slave clock path; the far end keeps it under a quarter of clk_i
      d.xs1 = transfer_clock_pin_i;                             // RULE_11 RULE_12
      d.xs2 = q.xs1;                                            // RULE_11
      d.xs3 = q.xs2;                                            // RULE_11
      d.oe  = sync && transfer_clock_direction_i;               // RULE_03
      // Divisor counter
      if (baud_divisor_low_wr_i || tick) begin
         d.baud_cnt = div;                                      // RULE_04
      end else begin
         d.baud_cnt = q.baud_cnt - 1'b1;
      end
      if (master && tick) begin
         d.xck = !q.xck;                                        // RULE_06
      end
      if (tick) begin
         d.tdiv = (q.tdiv == last) ? 4'h0 : q.tdiv + 4'h1;
      end
      if (tx_complete_clr_i) begin
         d.txc = 1'b0;
      end
      // Transmitter; next frame loads at the last bit's end, no idle gap
      if (tx_bit_en) begin
         case (q.tx_st)
            UCG_TX_SHIFT: begin
               if (q.tleft != 4'h1) begin
                  d.txd    = q.tframe[0];
                  d.tframe = {1'b1, q.tframe[FRAME_W-1:1]};
                  d.tleft  = q.tleft - 4'h1;
               end else if (!q.tbuf_empty && tx_enable_i) begin
                  d.tframe     = ucg_frame(q.tbuf, nbits, parity_mode_i);
                  d.txd        = 1'b0;                          // RULE_16
                  d.tframe     = {1'b1, d.tframe[FRAME_W-1:1]};
                  d.tleft      = flen;
                  d.tbuf_empty = 1'b1;
                  d.txc        = 1'b0;
               end else begin
                  d.txd   = 1'b1;
                  d.tx_st = UCG_TX_IDLE;
                  d.txc   = 1'b1;                               // RULE_19
               end
            end
            UCG_TX_IDLE: begin
               d.txd = 1'b1;                                    // RULE_21
               if (!q.tbuf_empty && tx_enable_i) begin
                  d.tframe     = ucg_frame(q.tbuf, nbits, parity_mode_i); // RULE_18
                  d.txd        = 1'b0;
                  d.tframe     = {1'b1, d.tframe[FRAME_W-1:1]};
                  d.tleft      = flen;
                  d.tbuf_empty = 1'b1;
                  d.txc        = 1'b0;
                  d.tx_st      = UCG_TX_SHIFT;
               end
            end
            default: begin
               d.tx_st = UCG_TX_IDLE;
            end
         endcase
      end
      // Single write buffer between FIFO and shifter
      if (f_valid && q.tbuf_empty) begin
         d.tbuf       = f_data;                                 // RULE_16
         d.tbuf_empty = 1'b0;
      end
      // Receiver sample counter and vote history
      if (tick) begin
         d.vote = {q.vote[1:0], serial_rx_pin_i};
         if (q.rx_st != UCG_RX_IDLE) begin
            d.rcnt = (q.rcnt == last) ? 4'h0 : q.rcnt + 4'h1;
         end
      end
      case (q.rx_st)
         UCG_RX_IDLE: begin
            if (!sync && tick && !serial_rx_pin_i) begin
               d.rx_st = UCG_RX_START;
               d.rcnt  = 4'h1;
            end else if (sync && sample_en && !serial_rx_pin_i) begin
               d.rx_st = UCG_RX_DATA;
               d.rbits = 4'h0;
            end
         end
         UCG_RX_START: begin
            if (rx_samp) begin
               d.rx_st = rbit ? UCG_RX_IDLE : UCG_RX_DATA;      // RULE_20
               d.rbits = 4'h0;
            end
         end
         UCG_RX_DATA: begin
            if (rx_samp) begin
               d.rsh   = {rbit, q.rsh[9:1]};
               d.rbits = q.rbits + 4'h1;
               if (q.rbits + 4'h1 == rtotal) begin
                  d.rx_st = UCG_RX_STOP;
               end
            end
         end
         UCG_RX_STOP: begin
            if (rx_samp) begin
               d.rx_st = UCG_RX_IDLE;                           // Second stop ignored
            end
         end
         default: begin
            d.rx_st = UCG_RX_IDLE;
         end
      endcase
      if (!rx_enable_i) begin
         d.rx_st = UCG_RX_IDLE;
      end
      // Two-entry receive buffer; pop first so a push in the same cycle wins
      if (rx_ready_i && q.hv) begin
         d.hv    = q.tv;
         d.hdata = q.tdata;
         d.hfe   = q.tfe;
         d.hpe   = q.tpe;
         d.tv    = 1'b0;
         d.ovr   = 1'b0;
      end
      if (rpush) begin
         if (!d.hv) begin
            d.hv    = 1'b1;                                     // RULE_17
            d.hdata = rdata;
            d.hfe   = rfe;
            d.hpe   = rpe;
         end else if (!d.tv) begin
            d.tv    = 1'b1;
            d.tdata = rdata;
            d.tfe   = rfe;
            d.tpe   = rpe;
         end else begin
            d.ovr = 1'b1;                                       // RULE_17
         end
      end
      // Power-off holds every register except the transmit FIFO at its reset value
      if (!on) begin
         d = CORE_RST;                                          // RULE_15
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q <= CORE_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register
   assign serial_tx_pin_o         = q.txd;
   assign transfer_clock_pin_o    = q.xck;
   assign transfer_clock_pin_oe_o = q.oe;                       // RULE_03
   assign rx_data_o               = q.hdata;
   assign rx_valid_o              = q.hv;
   assign rx_frame_err_o          = q.hfe;
   assign rx_parity_err_o         = q.hpe;
   assign rx_overrun_o            = q.ovr;
   assign tx_complete_o           = q.txc;                      // RULE_19
   assign tx_buf_empty_o          = q.tbuf_empty;               // RULE_19
   assign rx_complete_o           = q.hv;                       // RULE_19

   ////////////////////////////////////////////////////////////////////////////
   // Assertions and covers
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   a_baud_reload_wr: assert property (on && baud_divisor_low_wr_i ##1 on |-> q.baud_cnt == $past(div)) // RULE_04
      else $error("divisor not reloaded on low write");
   a_baud_count_down: assert property (on && !baud_divisor_low_wr_i && !tick ##1 on
                                       |-> q.baud_cnt == $past(q.baud_cnt) - 12'h001) // RULE_05
      else $error("divisor counter did not count down");
   a_baud_zero_reload: assert property (on && tick && !baud_divisor_low_wr_i ##1 on
                                        |-> q.baud_cnt == $past(div)) // RULE_05
      else $error("divisor counter not reloaded at zero");
   a_pin_async_off: assert property (!sync_mode_select_i |=> !transfer_clock_pin_oe_o) // RULE_03
      else $error("transfer clock driven in asynchronous mode");
   a_master_clk_toggle: assert property (on && master && tick ##1 on |-> q.xck != $past(q.xck)) // RULE_06
      else $error("master clock did not toggle on tick");
   a_slave_edge_lat: assert property (on && slave && $rose(transfer_clock_pin_i) ##1
                                      (on && slave && transfer_clock_pin_i) ##1 (on && slave) |-> rise) // RULE_11
      else $error("slave rising edge not seen two cycles later");
   a_master_sample_fall: assert property (on && master && !sync_clock_polarity_i && rx_samp
                                          |-> q.xck ##1 !q.xck) // RULE_14
      else $error("sampling not on falling edge with polarity zero");
   a_tx_start_low: assert property (q.tx_st == UCG_TX_IDLE ##1 q.tx_st == UCG_TX_SHIFT |-> !q.txd) // RULE_21
      else $error("frame did not open with a low start bit");
   a_tx_back_to_back: assert property (on && tx_bit_en && q.tx_st == UCG_TX_SHIFT && q.tleft == 4'h1 &&
                                       !q.tbuf_empty && tx_enable_i ##1 on
                                       |-> !q.txd && q.tx_st == UCG_TX_SHIFT) // RULE_16
      else $error("gap between buffered frames");
   a_rx_false_start: assert property (on && rx_enable_i && q.rx_st == UCG_RX_START && rx_samp && rbit ##1 on
                                      |-> q.rx_st == UCG_RX_IDLE) // RULE_20
      else $error("false start bit not rejected");
   a_rx_frame_err: assert property (rpush && rfe && !q.hv ##1 on |-> q.hv && q.hfe) // RULE_17
      else $error("missing stop bit not flagged");

   c_back_to_back: cover property (tx_bit_en && q.tx_st == UCG_TX_SHIFT && q.tleft == 4'h1 && !q.tbuf_empty);
   c_rx_frame: cover property (rpush && !rfe);
   c_slave_edges: cover property (slave && rise ##[1:20] fall);
   c_rx_overrun: cover property (rpush && q.hv && q.tv);
endmodule : ucg_core

// *** ucg_remote.sv ***
// Far-end model: echoes the line back to the core
// and makes slave clock edges only on demand.
`timescale 1ns/1ps
module ucg_remote (
   // Line and clock
   input  wire logic tx_i,
   output logic      rx_o,
   output logic      xck_o
);
   // Echo keeps the idle-high line level
   assign rx_o = tx_i;
   // Clock stands still between frames
   initial xck_o = 1'b0;
   // Held 4 cycles: stays under a quarter rate
   task automatic edge_out(input logic v);
      xck_o = v;
      #20;
   endtask : edge_out
endmodule : ucg_remote

// *** ucg_core_tb.sv ***
// Bench for the transceiver core, line looped back.
// Assumes the far-end model echoes tx onto rx.
`timescale 1ns/1ps
module ucg_core_tb;
   import ucg_pkg::*;
   ////////////////////////////////////////
   // Stimulus and observed signals
   logic clk_i = 0, resetn_i = 0, tx_valid_i = 0;
   logic serial_power_off_bit_i = 0, sync_mode_select_i = 0;
   logic double_speed_bit_i = 0, sync_clock_polarity_i = 0;
   logic transfer_clock_direction_i = 0, two_stop_i = 0;
   logic baud_divisor_low_wr_i = 0, rx_ready_i = 0;
   logic tx_enable_i = 1, rx_enable_i = 1, tx_complete_clr_i = 0;
   logic [3:0] baud_divisor_high_i = '0;
   logic [7:0] baud_divisor_low_i = '0;
   logic [2:0] data_bits_i = 3'h3;
   logic [1:0] parity_mode_i = '0;
   logic [DATA_W-1:0] tx_data_i = '0, rx_data_o;
   logic tx_ready_o, rx_valid_o, rx_frame_err_o, rx_parity_err_o;
   logic rx_overrun_o, tx_complete_o, tx_buf_empty_o, rx_complete_o;
   logic serial_tx_pin_o, serial_rx_pin_i, transfer_clock_pin_i;
   logic transfer_clock_pin_o, transfer_clock_pin_oe_o;
   int miscompares = 0, comparisons = 0, n;
   int dv[4] = '{0, 2, 1, 3};
   ucg_core DUT (.*);
   ucg_remote u_far (.tx_i(serial_tx_pin_o), .rx_o(serial_rx_pin_i), .xck_o(transfer_clock_pin_i));
   // 200 MHz system clock
   always #2.5 clk_i = ~clk_i;
   ////////////////////////////////////////
   // Helpers
   task automatic check(input logic [15:0] s, e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check
   task automatic end_of_test;
      if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   function automatic logic pick(input int k);
      return k == 0 ? serial_tx_pin_o : k == 1 ? tx_complete_o :
             k == 2 ? tx_buf_empty_o : k == 3 ? rx_valid_o : transfer_clock_pin_o;
   endfunction : pick
   // Counts cycles a level lasts; a stall ends the run
   task automatic span(input int k, input logic v);
      n = 0;
      while (pick(k) === v && n < 4000) begin
         @(negedge clk_i);
         n++;
      end
      if (n == 4000) begin
         miscompares++;
         end_of_test;
      end
   endtask : span
   task automatic send(input logic [DATA_W-1:0] w);
      @(negedge clk_i);
      tx_data_i = w;
      tx_valid_i = 1;
      @(negedge clk_i);
      tx_valid_i = 0;
   endtask : send
   // Divisor write also clears the complete flag
   task automatic cfg(input logic s, d, c, input int dvs);
      @(negedge clk_i);
      sync_mode_select_i = s;
      double_speed_bit_i = d;
      transfer_clock_direction_i = c;
      {baud_divisor_high_i, baud_divisor_low_i} = dvs[11:0];
      {baud_divisor_low_wr_i, tx_complete_clr_i} = 2'b11;
      @(negedge clk_i);
      {baud_divisor_low_wr_i, tx_complete_clr_i} = 2'b00;
   endtask : cfg
   task automatic pop;
      @(negedge clk_i);
      rx_ready_i = 1;
      @(negedge clk_i);
      rx_ready_i = 0;
   endtask : pop
   ////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (2) @(negedge clk_i);
      resetn_i = 1;
      check({serial_tx_pin_o, tx_buf_empty_o, tx_ready_o, transfer_clock_pin_oe_o, rx_valid_o}, 5'h1C);
      // Normal, double speed, normal, sync master
      for (int i = 0; i < 4; i++) begin
         cfg(i == 3, i == 1, i == 3, dv[i]);
         send(9'h001);
         check(transfer_clock_pin_oe_o, i == 3);
         span(0, 1);
         span(0, 0);
         check(n, (i == 3 ? 2 : i == 1 ? 8 : 16) * (dv[i] + 1));
         span(3, 0);
         check({rx_complete_o, rx_data_o}, 10'h201);
         span(1, 0);
         pop;
      end
      // Skip a partial high phase before timing a full one
      span(4, 1);
      span(4, 0);
      span(4, 1);
      check(n, 4);
      // Three frames queued, odd parity, two stops, no pops
      {parity_mode_i, two_stop_i} = 3'b111;
      cfg(0, 0, 0, 0);
      for (int i = 0; i < 3; i++) send(9'h0A5 + i);
      span(0, 1);
      span(1, 0);
      check(n > 572 && n < 580, 1);
      check({rx_valid_o, rx_frame_err_o, rx_parity_err_o, rx_overrun_o, rx_data_o}, 13'h12A5);
      pop;
      check({rx_overrun_o, rx_data_o}, 10'h0A6);
      pop;
      // Slave clock, change edge follows polarity
      {parity_mode_i, two_stop_i} = 3'b000;
      cfg(1, 0, 0, 0);
      send(9'h0FF);
      span(2, 1);
      check({transfer_clock_pin_oe_o, serial_tx_pin_o}, 2'b01);
      u_far.edge_out(1);
      check(serial_tx_pin_o, 0);
      sync_clock_polarity_i = 1;
      u_far.edge_out(0);
      check(serial_tx_pin_o, 1);
      serial_power_off_bit_i = 1;
      repeat (2) @(negedge clk_i);
      check({serial_tx_pin_o, tx_buf_empty_o}, 2'b11);
      end_of_test;
   end
endmodule : ucg_core_tb
